// *** hw/fmmp_regs.svh ***
// constants for the fan motor mode and protection block
`ifndef FMMP_REGS_SVH
`define FMMP_REGS_SVH

// ********************************
// time base
// ********************************
`define FMMP_CLK_HZ          25000000
`define FMMP_IDLE_MS         565
`define FMMP_LOCK_MS         500
`define FMMP_LOCK_HOLD_MS    5000
`define FMMP_BIAS_OFF_MS     556
`define FMMP_REL_CYC_MS      500
`define FMMP_REL_CYCLES      5
`define FMMP_MS_CYC(ms)      ((`FMMP_CLK_HZ / 1000) * (ms))

// ********************************
// phase advance in degrees
// ********************************
`define FMMP_ADV_LOW_DEG     8'h00
`define FMMP_ADV_MID_DEG     8'h0A
`define FMMP_ADV_HIGH_DEG    8'h19

`endif

// *** hw/fmmp_pkg.sv ***
// types for the fan motor mode and protection block
`default_nettype none
package fmmp_pkg;

    typedef enum logic [1:0] {
        FMMP_LVL_LOW,
        FMMP_LVL_MID,
        FMMP_LVL_HIGH
    } fmmp_level_e;

    typedef enum logic [1:0] {
        FMMP_OUT_DRIVE,
        FMMP_OUT_BRAKE,
        FMMP_OUT_OFF
    } fmmp_out_e;

    typedef enum logic [1:0] {
        FMMP_ST_ACTIVE,
        FMMP_ST_IDLE,
        FMMP_ST_SLEEP
    } fmmp_state_e;

    typedef struct packed {
        logic uv;
        logic ov;
        logic oc;
        logic ot;
    } fmmp_fault_s;

    typedef struct packed {
        fmmp_out_e  mode;
        logic       reverse;
        logic [7:0] advance_deg;
        logic [1:0] phase_order;
    } fmmp_drive_s;

endpackage
`default_nettype wire

// *** hw/fmmp_core.sv ***
// mode sequencing, lock timing and protection priority for the fan driver
// What this block does
// - speed command high: active, bias on
// - standby slow hall: cut sensor bias
// - speed pulse per 1, 2, 3 hall cycles
// - phase advance 0, 10 or 25 degrees
// - advance follows selected rotation direction
// - idle after 565 ms quiet, low command
// - sleep rise: outputs off, regulator off
// - 0.5 s no hall: brake, alarm low
// - lock released automatically after 5 s
// - lock released on hall, wake, power
// - undervoltage turns outputs off
// - overvoltage forces short brake
// - overcurrent forces short brake
// - overtemperature turns outputs off
// - direction low forward, high reverse
// - forward U V W, reverse U W V
`timescale 1ns/1ps
`default_nettype none
`include "fmmp_regs.svh"

module fmmp_core
    import fmmp_pkg::*;
#(
    parameter int unsigned IDLE_CYC     = `FMMP_MS_CYC(`FMMP_IDLE_MS),
    parameter int unsigned LOCK_CYC     = `FMMP_MS_CYC(`FMMP_LOCK_MS),
    parameter int unsigned HOLD_CYC     = `FMMP_MS_CYC(`FMMP_LOCK_HOLD_MS),
    parameter int unsigned BIAS_OFF_CYC = `FMMP_MS_CYC(`FMMP_BIAS_OFF_MS),
    parameter int unsigned REL_CYC      = `FMMP_MS_CYC(`FMMP_REL_CYC_MS),
    parameter int unsigned CW           = 28
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // comparator flags from the analog front end
    input  wire logic        hall_cmp,
    input  wire logic        speed_cmd_on,
    input  wire fmmp_fault_s fault,
    // mode and option pins
    input  wire logic        sleep_req,
    input  wire logic        direction_select,
    input  wire fmmp_level_e pulse_divide_select,
    input  wire fmmp_level_e phase_advance_select,
    // results
    output fmmp_drive_s      drive,
    output logic             sensor_bias_supply,
    output logic             internal_regulator,
    output logic             speed_pulse_out,
    output logic             lock_alarm_n,
    output fmmp_state_e      state
);

    // ********************************
    // hall edge detection and timers
    // ********************************
    logic          hall_q;
    logic          hall_rise;
    logic [CW-1:0] quiet_cnt;
    logic [CW-1:0] next_quiet_cnt;
    logic [CW-1:0] period_cnt;
    logic [CW-1:0] next_period_cnt;
    logic [CW-1:0] hold_cnt;
    logic [CW-1:0] next_hold_cnt;
    logic [2:0]    fast_cnt;
    logic [2:0]    next_fast_cnt;
    logic          locked;
    logic          next_locked;
    logic          sleep_q;
    logic          next_sleep_q;
    logic          wake;

    assign hall_rise = hall_cmp & ~hall_q;
    // wake is the falling edge of the sleep pin
    assign wake      = sleep_q & ~sleep_req;

    always_comb begin
        next_quiet_cnt  = quiet_cnt;
        next_period_cnt = period_cnt;
        next_hold_cnt   = hold_cnt;
        next_fast_cnt   = fast_cnt;
        next_locked     = locked;
        next_sleep_q    = sleep_req;
        // quiet time since the last rising hall edge, saturating
        if (hall_rise) begin
            next_quiet_cnt = '0;
        end else if (quiet_cnt != {CW{1'b1}}) begin
            next_quiet_cnt = quiet_cnt + 1'b1;
        end
        // count hall cycles at 2 Hz or faster
        if (hall_rise) begin
            next_period_cnt = '0;
            if (period_cnt <= CW'(REL_CYC) && fast_cnt != 3'(`FMMP_REL_CYCLES)) begin
                next_fast_cnt = fast_cnt + 3'd1;
            end else if (period_cnt > CW'(REL_CYC)) begin
                // a slow edge restarts the run of fast cycles
                next_fast_cnt = 3'd1;
            end
        end else if (period_cnt != {CW{1'b1}}) begin
            next_period_cnt = period_cnt + 1'b1;
        end
        if (locked) begin
            next_hold_cnt = hold_cnt + 1'b1;
            if (hold_cnt >= CW'(HOLD_CYC - 1)) begin
                next_locked    = 1'b0;
                next_quiet_cnt = '0;
            end
            if (fast_cnt == 3'(`FMMP_REL_CYCLES) || wake || fault.uv) begin
                next_locked    = 1'b0;
                next_quiet_cnt = '0;
            end
        end else if (state == FMMP_ST_ACTIVE && speed_cmd_on
                     && quiet_cnt >= CW'(LOCK_CYC)) begin
            // lock only arms while the motor is commanded to turn
            // lock on missing hall
            next_locked   = 1'b1;
            next_hold_cnt = '0;
            next_fast_cnt = '0;
        end
        // sleep and undervoltage clear the lock outright
        if (state == FMMP_ST_SLEEP || fault.uv) begin
            next_locked = 1'b0;
        end
        // restart quiet time on wake or idle exit
        // else a stale count re-arms the lock at once
        if (state != FMMP_ST_ACTIVE || fault.uv) begin
            next_quiet_cnt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // follow the pin so release sees no false hall edge
            hall_q     <= hall_cmp;
            quiet_cnt  <= '0;
            // saturated so the first edge never counts as fast
            period_cnt <= '1;
            hold_cnt   <= '0;
            fast_cnt   <= '0;
            locked     <= 1'b0;
            sleep_q    <= 1'b0;
        end else begin
            hall_q     <= hall_cmp;
            quiet_cnt  <= next_quiet_cnt;
            period_cnt <= next_period_cnt;
            hold_cnt   <= next_hold_cnt;
            fast_cnt   <= next_fast_cnt;
            locked     <= next_locked;
            sleep_q    <= next_sleep_q;
        end
    end

    // ********************************
    // mode sequencing
    // ********************************
    fmmp_state_e next_state;
    logic        next_bias;

    always_comb begin
        next_state = state;
        next_bias  = sensor_bias_supply;
        case (state)
            FMMP_ST_ACTIVE: begin
                if (speed_cmd_on) begin
                    next_bias = 1'b1;
                end else if (quiet_cnt >= CW'(BIAS_OFF_CYC)) begin
                    next_bias = 1'b0;
                end
                if (!speed_cmd_on && quiet_cnt > CW'(IDLE_CYC)) begin
                    next_state = FMMP_ST_IDLE;
                end
            end
            FMMP_ST_IDLE: begin
                if (speed_cmd_on || fault.uv) begin
                    next_state = FMMP_ST_ACTIVE;
                    next_bias  = 1'b1;
                end
            end
            FMMP_ST_SLEEP: begin
                next_bias = 1'b0;
                if (wake || fault.uv) begin
                    next_state = FMMP_ST_ACTIVE;
                    next_bias  = 1'b1;
                end
            end
            default: begin
                next_state = FMMP_ST_ACTIVE;
            end
        endcase
        // only a fresh rise of the pin enters sleep
        // sleep rising edge wins at once
        if (sleep_req && !sleep_q) begin
            next_state = FMMP_ST_SLEEP;
            next_bias  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state              <= FMMP_ST_ACTIVE;
            sensor_bias_supply <= 1'b1;
        end else begin
            state              <= next_state;
            sensor_bias_supply <= next_bias;
        end
    end

    // ********************************
    // speed pulse divider
    // ********************************
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic [2:0] div_len;
    logic       next_pulse;

    always_comb begin
        case (pulse_divide_select)
            FMMP_LVL_LOW:  div_len = 3'd3;
            FMMP_LVL_MID:  div_len = 3'd2;
            default:       div_len = 3'd1;
        endcase
        next_div_cnt = div_cnt;
        next_pulse   = speed_pulse_out;
        // both hall edges count: N edges a half pulse is N hall cycles a pulse
        if (hall_rise || (hall_cmp != hall_q)) begin
            if (div_cnt + 3'd1 >= div_len) begin
                next_div_cnt = 3'd0;
                next_pulse   = ~speed_pulse_out;
            end else begin
                next_div_cnt = div_cnt + 3'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt         <= 3'd0;
            speed_pulse_out <= 1'b0;
        end else begin
            div_cnt         <= next_div_cnt;
            speed_pulse_out <= next_pulse;
        end
    end

    // ********************************
    // drive command and priority
    // ********************************
    fmmp_drive_s next_drive;
    logic        next_reg;
    logic        next_alarm_n;

    always_comb begin
        next_drive       = '0;
        // regulator drops only in sleep; idle keeps it up
        next_reg         = (next_state != FMMP_ST_SLEEP);
        // alarm follows the lock flag in the same cycle
        next_alarm_n     = ~next_locked;
        next_drive.reverse = direction_select;
        // commutation order code, 0 = U V W, 1 = U W V
        next_drive.phase_order = direction_select ? 2'd1 : 2'd0;
        case (phase_advance_select)
            FMMP_LVL_LOW:  next_drive.advance_deg = `FMMP_ADV_LOW_DEG;
            FMMP_LVL_MID:  next_drive.advance_deg = `FMMP_ADV_MID_DEG;
            default:       next_drive.advance_deg = `FMMP_ADV_HIGH_DEG;
        endcase
        // advance shares the direction bit, applied downstream
        if (next_state == FMMP_ST_SLEEP || fault.uv || fault.ot) begin
            next_drive.mode = FMMP_OUT_OFF;
        end else if (fault.ov || fault.oc || next_locked || next_state == FMMP_ST_IDLE) begin
            next_drive.mode = FMMP_OUT_BRAKE;
        end else begin
            next_drive.mode = FMMP_OUT_DRIVE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive              <= '0;
            internal_regulator <= 1'b1;
            lock_alarm_n       <= 1'b1;
        end else begin
            drive              <= next_drive;
            internal_regulator <= next_reg;
            lock_alarm_n       <= next_alarm_n;
        end
    end

endmodule

`default_nettype wire

// *** testbench/fmmp_properties.sv ***
// port assertions for the fan motor mode and protection core
`timescale 1ns/1ps
`default_nettype none
module fmmp_properties
    import fmmp_pkg::*;
#(
    parameter int HOLD_CYC = 200
) (
    // clock, reset and inputs
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hall_cmp,
    input wire logic        speed_cmd_on,
    input wire fmmp_fault_s fault,
    input wire logic        sleep_req,
    input wire logic        direction_select,
    input wire fmmp_level_e pulse_divide_select,
    input wire fmmp_level_e phase_advance_select,
    // results
    input wire fmmp_drive_s drive,
    input wire logic        sensor_bias_supply,
    input wire logic        internal_regulator,
    input wire logic        speed_pulse_out,
    input wire logic        lock_alarm_n,
    input wire fmmp_state_e state
);
    localparam int HOLD_LIM = HOLD_CYC + 3;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_bias; speed_cmd_on && !sleep_req && !fault.uv |=> sensor_bias_supply; endproperty
    a_bias: assert property (p_bias) else $error("bias not on");
    property p_idle; state == FMMP_ST_IDLE |-> internal_regulator; endproperty
    a_idle: assert property (p_idle) else $error("regulator off in idle");
    property p_pulse; $changed(speed_pulse_out) |-> $past(hall_cmp, 2) != $past(hall_cmp, 3)
        || $past(hall_cmp, 1) != $past(hall_cmp, 2); endproperty
    a_pulse: assert property (p_pulse) else $error("pulse moved without hall edge");
    property p_adv; 1 |=> drive.advance_deg == ($past(phase_advance_select) == FMMP_LVL_HIGH ?
        8'h19 : $past(phase_advance_select) == FMMP_LVL_MID ? 8'h0A : 8'h00); endproperty
    a_adv: assert property (p_adv) else $error("advance wrong");
    property p_dir; 1 |=> drive.reverse == $past(direction_select)
        && drive.phase_order == {1'b0, $past(direction_select)}; endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    property p_sleep; $rose(sleep_req) && !fault.uv |=> drive.mode == FMMP_OUT_OFF
        && !internal_regulator && state == FMMP_ST_SLEEP; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
    property p_wake; $fell(sleep_req) && !fault.uv |=> internal_regulator && lock_alarm_n; endproperty
    a_wake: assert property (p_wake) else $error("wake wrong");
    property p_off; fault.uv || fault.ot |=> drive.mode == FMMP_OUT_OFF; endproperty
    a_off: assert property (p_off) else $error("outputs not off");
    property p_brk; (fault.ov || fault.oc) && !fault.uv && !fault.ot && !sleep_req
        |=> drive.mode == FMMP_OUT_BRAKE; endproperty
    a_brk: assert property (p_brk) else $error("no short brake");
    property p_lock; $fell(lock_alarm_n) |-> drive.mode != FMMP_OUT_DRIVE; endproperty
    a_lock: assert property (p_lock) else $error("lock still driving");
    property p_hold; $fell(lock_alarm_n) |-> ##[1:HOLD_LIM] lock_alarm_n; endproperty
    a_hold: assert property (p_hold) else $error("lock not released");
endmodule
`default_nettype wire

// *** testbench/fmmp_hall_model.sv ***
// hall element model: square wave while the rotor turns, level held at rest
`timescale 1ns/1ps
`default_nettype none
module fmmp_hall_model #(
    parameter int HALF = 4
) (
    // clock and rotor control
    input  wire logic clk,
    input  wire logic run,
    // comparator output
    output var logic  hall_cmp
);
    int cnt = 0;
    initial hall_cmp = 1'b0;
    always @(posedge clk) begin
        if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                hall_cmp <= ~hall_cmp;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/fmmp_core_tb.sv ***
// testbench for the fan motor mode and protection core
`timescale 1ns/1ps
`default_nettype none
module fmmp_core_tb
    import fmmp_pkg::*;
;
    localparam int LOCK = 40;
    localparam int HOLD = 200;
    localparam int IDLE = 50;
    logic        clk = 1'b0, rst_n = 1'b0, speed_cmd_on = 1'b1, sleep_req = 1'b0;
    logic        dir = 1'b0, run = 1'b0, hall_cmp, hall_q = 1'b0, pulse_q = 1'b0;
    logic        bias, regu, pulse, alarm_n;
    fmmp_fault_s fault = '0;
    fmmp_level_e div_sel = FMMP_LVL_HIGH, adv_sel = FMMP_LVL_LOW;
    fmmp_drive_s drive;
    fmmp_state_e state;
    int          n_fail = 0, n_checks = 0, cyc = 0, edges = 0, togs = 0, e0, t0;
    logic [5:0]  ftab [6] = '{6'h22, 6'h11, 6'h09, 6'h06, 6'h32, 6'h19};

    fmmp_core #(.IDLE_CYC(IDLE), .LOCK_CYC(LOCK), .HOLD_CYC(HOLD), .BIAS_OFF_CYC(45),
        .REL_CYC(40)) u_dut (.clk(clk), .rst_n(rst_n), .hall_cmp(hall_cmp),
        .speed_cmd_on(speed_cmd_on), .fault(fault), .sleep_req(sleep_req),
        .direction_select(dir), .pulse_divide_select(div_sel),
        .phase_advance_select(adv_sel), .drive(drive), .sensor_bias_supply(bias),
        .internal_regulator(regu), .speed_pulse_out(pulse), .lock_alarm_n(alarm_n),
        .state(state));
    fmmp_hall_model #(.HALF(4)) u_hall (.clk(clk), .run(run), .hall_cmp(hall_cmp));

    initial forever #20 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reset_dut();
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
    endtask
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // edge counters and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        hall_q <= hall_cmp;
        pulse_q <= pulse;
        if (hall_q !== hall_cmp) edges <= edges + 1;
        if (pulse_q !== pulse) togs <= togs + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        reset_dut();
        chk(drive, '0);
        chk({bias, regu, pulse, alarm_n, state}, {4'hD, FMMP_ST_ACTIVE});
        for (int d = 0; d < 2; d++) begin
            for (int a = 0; a < 3; a++) begin
                dir = d[0];
                adv_sel = fmmp_level_e'(a);
                tick(2);
                chk({drive.reverse, drive.phase_order}, {d[0], 1'b0, d[0]});
                chk(drive.advance_deg, a == 2 ? 16'h0019 : a == 1 ? 16'h000A : 16'h0000);
            end
        end
        for (int s = 0; s < 3; s++) begin
            div_sel = fmmp_level_e'(s);
            reset_dut();
            e0 = edges;
            t0 = togs;
            run = 1'b1;
            for (int w = 0; w < 200 && edges - e0 < 12; w++) tick(1);
            run = 1'b0;
            tick(3);
            chk(16'(togs - t0), 16'(12 / (3 - s)));
        end
        tick(LOCK + 4);
        chk({alarm_n, drive.mode}, {1'b0, FMMP_OUT_BRAKE});
        tick(HOLD - 20);
        chk(alarm_n, 1'b0);
        tick(15);
        chk(alarm_n, 1'b1);
        tick(LOCK + 4);
        chk(alarm_n, 1'b0);
        run = 1'b1;
        tick(56);
        chk(alarm_n, 1'b1);
        run = 1'b0;
        tick(LOCK + 4);
        sleep_req = 1'b1;
        tick(2);
        chk({regu, state, drive.mode}, {1'b0, FMMP_ST_SLEEP, FMMP_OUT_OFF});
        sleep_req = 1'b0;
        tick(2);
        chk({regu, alarm_n, state}, {2'b11, FMMP_ST_ACTIVE});
        speed_cmd_on = 1'b0;
        tick(IDLE + 6);
        chk({regu, bias, state, drive.mode}, {2'b10, FMMP_ST_IDLE, FMMP_OUT_BRAKE});
        speed_cmd_on = 1'b1;
        tick(2);
        chk({bias, state}, {1'b1, FMMP_ST_ACTIVE});
        run = 1'b1;
        for (int i = 0; i < 6; i++) begin
            fault = fmmp_fault_s'(ftab[i][5:2]);
            tick(3);
            chk(drive.mode, ftab[i][1:0]);
            fault = '0;
            tick(4);
            chk(drive.mode, FMMP_OUT_DRIVE);
        end
        end_of_test();
    end
endmodule

bind fmmp_core fmmp_properties #(.HOLD_CYC(HOLD_CYC)) u_props (.clk(clk), .rst_n(rst_n),
    .hall_cmp(hall_cmp), .speed_cmd_on(speed_cmd_on), .fault(fault), .sleep_req(sleep_req),
    .direction_select(direction_select), .pulse_divide_select(pulse_divide_select),
    .phase_advance_select(phase_advance_select), .drive(drive),
    .sensor_bias_supply(sensor_bias_supply), .internal_regulator(internal_regulator),
    .speed_pulse_out(speed_pulse_out), .lock_alarm_n(lock_alarm_n), .state(state));
`default_nettype wire
